// ===== hw/rtk_map.vh
// Constants for the timekeeping register bank and write latch
// Operation
// - A status, array or id-area write completes only if the write latch was already set.
// - The latch-set instruction sets the latch and the latch-clear instruction clears it.
// - The latch is cleared after power-up (reset).
// - The latch clears after a completed latch-clear, status, array or id-area write.
// - Timekeeping registers decode byte addresses 0x00 to 0x1F.
// - A burst started in the timekeeping space wraps its address from 0x1F to 0x00.
// - Timekeeping registers are battery backed only while the backup enable bit is set.
// - Unused bits and unimplemented addresses in the space read as zero.
// - Any written value is stored without range or format checking.
// - Latch-set is opcode 0x06 and latch-clear is 0x04, sent MSB first.
// - The latch is set only on chip select rising after all eight latch-set bits.
// - Register read is 0x13 and write is 0x12, each followed by an 8-bit address.
`ifndef RTK_MAP_VH
`define RTK_MAP_VH
`define RTK_OP_LATCH_SET 8'h06
`define RTK_OP_LATCH_CLR 8'h04
`define RTK_OP_ARRAY_WR 8'h02
`define RTK_OP_STATUS_WR 8'h01
`define RTK_OP_ID_WR 8'h32
`define RTK_OP_REG_RD 8'h13
`define RTK_OP_REG_WR 8'h12
`define RTK_REG_FIRST 5'h00
`define RTK_REG_LAST 5'h1F
`define RTK_SPACE_TOP 3'h0
`define RTK_ADDR_DAY 5'h04
`define RTK_BIT_BAT_EN 3
`define RTK_BIT_BAT_FLAG 4
`define RTK_BIT_OSC_ON 5
`define RTK_BIT_LEAP 5
`define RTK_ADDR_MONTH 5'h06
`define RTK_A_SUBSEC 5'h00
`define RTK_A_SEC 5'h01
`define RTK_A_MIN 5'h02
`define RTK_A_HOUR 5'h03
`define RTK_A_DATE 5'h05
`define RTK_A_YEAR 5'h07
`define RTK_A_OUT_CTRL 5'h08
`define RTK_A_TRIM 5'h09
`define RTK_A_WDOG 5'h0A
`define RTK_A_EVENT 5'h0B
`define RTK_A_AL1_SEC 5'h0C
`define RTK_A_AL1_MIN 5'h0D
`define RTK_A_AL1_HOUR 5'h0E
`define RTK_A_AL1_DAY 5'h0F
`define RTK_A_AL1_DATE 5'h10
`define RTK_A_AL1_MONTH 5'h11
`define RTK_A_AL2_SUBSEC 5'h12
`define RTK_A_AL2_SEC 5'h13
`define RTK_A_AL2_MIN 5'h14
`define RTK_A_AL2_HOUR 5'h15
`define RTK_A_AL2_DAY 5'h16
`define RTK_A_AL2_DATE 5'h17
`define RTK_A_DN_MIN 5'h18
`define RTK_A_DN_HOUR 5'h19
`define RTK_A_DN_DATE 5'h1A
`define RTK_A_DN_DAYMON 5'h1B
`define RTK_A_UP_MIN 5'h1C
`define RTK_A_UP_HOUR 5'h1D
`define RTK_A_UP_DATE 5'h1E
`define RTK_A_UP_DAYMON 5'h1F
`define RTK_MASK_ALL 8'hFF
`define RTK_MASK_LOW7 8'h7F
`define RTK_MASK_LOW6 8'h3F
`define RTK_MASK_LOW5 8'h1F
`define RTK_BIT_LAST 3'h7
`endif

// ===== hw/rtk_regs.v
// SPI slave for the timekeeping register bank with the write-enable latch
`timescale 1ns/1ns
`include "rtk_map.vh"
module rtk_regs #(
  parameter NREG = 32
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_cs_n,
  input wire i_sck,
  input wire i_si,
  input wire i_vcc_ok,
  input wire i_osc_on,
  input wire i_leap,
  output reg o_so,
  output reg o_so_oe_n,
  output reg o_write_latch,
  output reg o_nv_write,
  output reg [7:0] o_nv_opcode,
  output reg o_battery_backup_enable,
  output reg o_regs_retained
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [1:0] cs_s_q;
  reg [1:0] sck_s_q;
  reg [1:0] si_s_q;
  reg [1:0] vcc_s_q;
  reg [1:0] osc_s_q;
  reg [1:0] leap_s_q;
  reg sck_old_q;
  reg cs_old_q;
  always @(posedge i_clk) begin
    cs_s_q <= {cs_s_q[0], i_cs_n};
    sck_s_q <= {sck_s_q[0], i_sck};
    si_s_q <= {si_s_q[0], i_si};
    vcc_s_q <= {vcc_s_q[0], i_vcc_ok};
    osc_s_q <= {osc_s_q[0], i_osc_on};
    leap_s_q <= {leap_s_q[0], i_leap};
  end
  always @(posedge i_clk) begin
    if (i_rst) begin
      sck_old_q <= 1'b0;
      cs_old_q <= 1'b1;
    end else begin
      sck_old_q <= sck_s_q[1];
      cs_old_q <= cs_s_q[1];
    end
  end
  wire sel = ~cs_s_q[1];
  wire sck_rise = sel & sck_s_q[1] & ~sck_old_q;
  wire sck_fall = sel & ~sck_s_q[1] & sck_old_q;
  wire cs_rise = cs_s_q[1] & ~cs_old_q;

  // ----------------------------------------
  // Frame state
  // ----------------------------------------
  localparam ST_OP = 4'b0001;
  localparam ST_ADDR = 4'b0010;
  localparam ST_DATA = 4'b0100;
  localparam ST_SKIP = 4'b1000;
  reg [3:0] st_q;
  reg [3:0] st_d;
  reg [2:0] bit_q;
  reg [7:0] sh_q;
  reg [7:0] op_q;
  reg [4:0] addr_q;
  reg in_space_q;
  reg byte_done_q;
  reg [7:0] regs_q [0:NREG-1];
  wire [7:0] sh_next = {sh_q[6:0], si_s_q[1]};
  wire byte_end = sck_rise & (bit_q == `RTK_BIT_LAST);
  wire is_rd = (op_q == `RTK_OP_REG_RD);
  wire is_wr = (op_q == `RTK_OP_REG_WR);
  wire is_nv = (op_q == `RTK_OP_ARRAY_WR) | (op_q == `RTK_OP_STATUS_WR) |
    (op_q == `RTK_OP_ID_WR);

  always @* begin
    st_d = st_q;
    if (byte_end) begin
      case (st_q)
        ST_OP: begin
          if ((sh_next == `RTK_OP_REG_RD) | (sh_next == `RTK_OP_REG_WR) |
              (sh_next == `RTK_OP_ARRAY_WR) | (sh_next == `RTK_OP_STATUS_WR) |
              (sh_next == `RTK_OP_ID_WR)) begin
            st_d = ST_ADDR;
          end else begin
            st_d = ST_SKIP;
          end
        end
        ST_ADDR: st_d = ST_DATA;
        default: st_d = st_q;
      endcase
    end
  end

  // Read data view: zero for unused bits; outside the space o_so is forced to zero instead
  function [7:0] rd_view;
    input [4:0] a;
    input [7:0] v;
    begin
      rd_view = v & rmask(a);
      if (a == `RTK_ADDR_DAY) begin
        rd_view[`RTK_BIT_OSC_ON] = osc_s_q[1];
      end
      if (a == `RTK_ADDR_MONTH) begin
        rd_view[`RTK_BIT_LEAP] = leap_s_q[1];
      end
    end
  endfunction

  // Writable-bit masks; unused and read-only positions never store
  function [7:0] wmask;
    input [4:0] a;
    begin
      if (a == `RTK_A_SUBSEC) begin
        wmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_SEC) begin
        wmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_MIN) begin
        wmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_HOUR) begin
        wmask = `RTK_MASK_ALL;
      end else if (a == `RTK_ADDR_DAY) begin
        wmask = `RTK_MASK_LOW5;
      end else if (a == `RTK_A_DATE) begin
        wmask = `RTK_MASK_LOW6;
      end else if (a == `RTK_ADDR_MONTH) begin
        wmask = `RTK_MASK_LOW5;
      end else if (a == `RTK_A_YEAR) begin
        wmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_OUT_CTRL) begin
        wmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_TRIM) begin
        wmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_WDOG) begin
        wmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_EVENT) begin
        wmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_AL1_SEC) begin
        wmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_AL1_MIN) begin
        wmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_AL1_HOUR) begin
        wmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_AL1_DAY) begin
        wmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_AL1_DATE) begin
        wmask = `RTK_MASK_LOW6;
      end else if (a == `RTK_A_AL1_MONTH) begin
        wmask = `RTK_MASK_LOW5;
      end else if (a == `RTK_A_AL2_SUBSEC) begin
        wmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_AL2_SEC) begin
        wmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_AL2_MIN) begin
        wmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_AL2_HOUR) begin
        wmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_AL2_DAY) begin
        wmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_AL2_DATE) begin
        wmask = `RTK_MASK_LOW6;
      end else if (a == `RTK_A_DN_MIN) begin
        wmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_DN_HOUR) begin
        wmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_DN_DATE) begin
        wmask = `RTK_MASK_LOW6;
      end else if (a == `RTK_A_DN_DAYMON) begin
        wmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_UP_MIN) begin
        wmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_UP_HOUR) begin
        wmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_UP_DATE) begin
        wmask = `RTK_MASK_LOW6;
      end else begin
        wmask = `RTK_MASK_ALL;
      end
    end
  endfunction

  // Readable-bit masks; these also pass the status bits driven by hardware
  function [7:0] rmask;
    input [4:0] a;
    begin
      if (a == `RTK_A_SUBSEC) begin
        rmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_SEC) begin
        rmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_MIN) begin
        rmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_HOUR) begin
        rmask = `RTK_MASK_ALL;
      end else if (a == `RTK_ADDR_DAY) begin
        rmask = `RTK_MASK_LOW6;
      end else if (a == `RTK_A_DATE) begin
        rmask = `RTK_MASK_LOW6;
      end else if (a == `RTK_ADDR_MONTH) begin
        rmask = `RTK_MASK_LOW6;
      end else if (a == `RTK_A_YEAR) begin
        rmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_OUT_CTRL) begin
        rmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_TRIM) begin
        rmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_WDOG) begin
        rmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_EVENT) begin
        rmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_AL1_SEC) begin
        rmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_AL1_MIN) begin
        rmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_AL1_HOUR) begin
        rmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_AL1_DAY) begin
        rmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_AL1_DATE) begin
        rmask = `RTK_MASK_LOW6;
      end else if (a == `RTK_A_AL1_MONTH) begin
        rmask = `RTK_MASK_LOW5;
      end else if (a == `RTK_A_AL2_SUBSEC) begin
        rmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_AL2_SEC) begin
        rmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_AL2_MIN) begin
        rmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_AL2_HOUR) begin
        rmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_AL2_DAY) begin
        rmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_AL2_DATE) begin
        rmask = `RTK_MASK_LOW6;
      end else if (a == `RTK_A_DN_MIN) begin
        rmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_DN_HOUR) begin
        rmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_DN_DATE) begin
        rmask = `RTK_MASK_LOW6;
      end else if (a == `RTK_A_DN_DAYMON) begin
        rmask = `RTK_MASK_ALL;
      end else if (a == `RTK_A_UP_MIN) begin
        rmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_UP_HOUR) begin
        rmask = `RTK_MASK_LOW7;
      end else if (a == `RTK_A_UP_DATE) begin
        rmask = `RTK_MASK_LOW6;
      end else begin
        rmask = `RTK_MASK_ALL;
      end
    end
  endfunction

  // ----------------------------------------
  // Serial engine
  // ----------------------------------------
  integer k;
  always @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= ST_OP;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      op_q <= 8'h00;
      addr_q <= 5'h00;
      in_space_q <= 1'b0;
      byte_done_q <= 1'b0;
      o_so <= 1'b0;
      o_so_oe_n <= 1'b1;
      o_write_latch <= 1'b0;
      o_nv_write <= 1'b0;
      o_nv_opcode <= 8'h00;
      o_battery_backup_enable <= 1'b0;
      o_regs_retained <= 1'b1;
      for (k = 0; k < NREG; k = k + 1) begin
        regs_q[k] <= 8'h00;
      end
    end else begin
      o_nv_write <= 1'b0;
      o_battery_backup_enable <= regs_q[`RTK_ADDR_DAY][`RTK_BIT_BAT_EN];
      // Loss of supply without backup enabled drops the bank
      if (~vcc_s_q[1] & ~regs_q[`RTK_ADDR_DAY][`RTK_BIT_BAT_EN]) begin
        o_regs_retained <= 1'b0;
        for (k = 0; k < NREG; k = k + 1) begin
          regs_q[k] <= 8'h00;
        end
      end else if (~vcc_s_q[1]) begin
        regs_q[`RTK_ADDR_DAY][`RTK_BIT_BAT_FLAG] <= 1'b1;
      end
      if (vcc_s_q[1] & cs_rise) begin
        o_regs_retained <= 1'b1;
      end
      if (cs_s_q[1]) begin
        st_q <= ST_OP;
        bit_q <= 3'h0;
        o_so_oe_n <= 1'b1;
        o_so <= 1'b0;
        if (cs_rise) begin
          // Latch opcodes park the frame in skip; a further whole byte wipes op_q
          if ((st_q == ST_SKIP) & (bit_q == 3'h0) & (op_q == `RTK_OP_LATCH_SET)) begin
            o_write_latch <= 1'b1;
          end else if ((st_q == ST_SKIP) & (bit_q == 3'h0) &
              (op_q == `RTK_OP_LATCH_CLR)) begin
            o_write_latch <= 1'b0;
          end else if ((st_q == ST_DATA) & is_nv & byte_done_q & (bit_q == 3'h0) &
              o_write_latch) begin
            o_nv_write <= 1'b1;
            o_nv_opcode <= op_q;
            o_write_latch <= 1'b0;
          end
          // Partial data bytes fall through and keep the latch
          op_q <= 8'h00;
          byte_done_q <= 1'b0;
        end
      end else begin
        st_q <= st_d;
        if (sck_rise) begin
          bit_q <= bit_q + 3'h1;
          sh_q <= sh_next;
        end
        if (byte_end) begin
          case (st_q)
            ST_OP: op_q <= sh_next;
            ST_ADDR: begin
              addr_q <= sh_next[4:0];
              in_space_q <= (sh_next[7:5] == `RTK_SPACE_TOP);
              sh_q <= rd_view(sh_next[4:0], regs_q[sh_next[4:0]]);
            end
            ST_DATA: begin
              byte_done_q <= 1'b1;
              if (is_wr & in_space_q) begin
                regs_q[addr_q] <= sh_next & wmask(addr_q);
                // Supply loss in the same cycle as a clear: the set wins
                if ((addr_q == `RTK_ADDR_DAY) & ~vcc_s_q[1] &
                    regs_q[`RTK_ADDR_DAY][`RTK_BIT_BAT_EN]) begin
                  regs_q[addr_q][`RTK_BIT_BAT_FLAG] <= 1'b1;
                end
              end
              // Burst stays inside the space
              addr_q <= (addr_q == `RTK_REG_LAST) ? `RTK_REG_FIRST : addr_q + 5'h01;
              sh_q <= rd_view(addr_q + 5'h01, regs_q[addr_q + 5'h01]);
            end
            ST_SKIP: op_q <= 8'h00;
            default: op_q <= op_q;
          endcase
        end
        // Shift out on the falling edge so the host samples on the rising one
        if (sck_fall & (st_q == ST_DATA) & is_rd) begin
          o_so_oe_n <= 1'b0;
          o_so <= in_space_q ? sh_q[7] : 1'b0;
        end
      end
    end
  end
endmodule

// ===== tb/rtk_regs_asserts.sv
// Port checks for the timekeeping register bank
`timescale 1ns/1ns
module rtk_regs_asserts #(
  parameter NREG = 32
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_cs_n,
  input wire o_so_oe_n,
  input wire o_write_latch,
  input wire o_nv_write,
  input wire [7:0] o_nv_opcode,
  input wire o_battery_backup_enable,
  input wire o_regs_retained
);
  // ------
  // Checks
  // ------
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  sequence commit_seq;
    o_nv_write;
  endsequence
  sequence drop_seq;
    ##[0:4] !o_write_latch;
  endsequence
  need_latch_a: assert property (o_nv_write |-> $past(o_write_latch))
    else $error("commit without latch");
  nv_code_a: assert property (o_nv_write |-> o_nv_opcode inside {8'h02, 8'h01, 8'h32})
    else $error("bad commit code");
  commit_clear_a: assert property (commit_seq |-> drop_seq)
    else $error("latch kept after commit");
  set_on_cs_a: assert property ($rose(o_write_latch) |-> $past(i_cs_n) && $past(i_cs_n, 2))
    else $error("latch set while selected");
  clr_on_cs_a: assert property ($fell(o_write_latch) |-> $past(i_cs_n))
    else $error("latch cleared while selected");
  // Own disable: the release edge itself is what is checked
  reset_state_a: assert property (disable iff (1'b0) $fell(i_rst) |-> !o_write_latch && !o_nv_write)
    else $error("latch not clear after reset");
  so_release_a: assert property (i_cs_n [*8] |-> o_so_oe_n)
    else $error("output driven while idle");
  bank_lost_a: assert property ($fell(o_regs_retained) |-> !$past(o_battery_backup_enable))
    else $error("bank lost with backup on");
endmodule
bind rtk_regs rtk_regs_asserts #(.NREG(NREG)) u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_cs_n(i_cs_n), .o_so_oe_n(o_so_oe_n), .o_write_latch(o_write_latch),
  .o_nv_write(o_nv_write), .o_nv_opcode(o_nv_opcode),
  .o_battery_backup_enable(o_battery_backup_enable), .o_regs_retained(o_regs_retained));

// ===== tb/rtk_host.sv
// Serial host model driving the register bank pins
`timescale 1ns/1ns
module rtk_host (
  input wire i_clk,
  input wire i_so,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si
);
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Sends n bits MSB first, half period of four clocks
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    for (int i = 7; i > 7 - n; i--) begin
      o_si <= tx[i];
      tick(4);
      o_sck <= 1'b1;
      tick(4);
      rx[i] = i_so;
      o_sck <= 1'b0;
    end
  endtask
  // Deselect flips the data line so no stale bit can pass for a driven one
  task automatic sel(input logic on);
    tick(4);
    o_cs_n <= !on;
    if (!on) o_si <= !o_si;
    tick(8);
  endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the register bank and write latch
`timescale 1ns/1ns
module testbench;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic vcc = 1'b1;
  logic osc = 1'b1;
  logic lp = 1'b1;
  wire cs_n, sck, si, so, so_oe_n, latch, nv_wr, bbe, kept;
  wire [7:0] nv_op;
  int fails = 0;
  int tests_run = 0;
  int nv_cnt = 0;
  logic [7:0] rx;
  logic [7:0] ops [3] = '{8'h02, 8'h01, 8'h32};
  initial forever #25 i_clk = ~i_clk;
  always @(posedge i_clk) if (nv_wr) nv_cnt++;
  rtk_regs u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
    .i_vcc_ok(vcc), .i_osc_on(osc), .i_leap(lp), .o_so(so), .o_so_oe_n(so_oe_n),
    .o_write_latch(latch), .o_nv_write(nv_wr), .o_nv_opcode(nv_op),
    .o_battery_backup_enable(bbe), .o_regs_retained(kept));
  rtk_host u_host (.i_clk(i_clk), .i_so(so_oe_n ? 1'bz : so), .o_cs_n(cs_n), .o_sck(sck),
    .o_si(si));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic frame(input logic [7:0] q[$], input int last = 8);
    u_host.sel(1'b1);
    foreach (q[i]) u_host.xfer(q[i], i == q.size() - 1 ? last : 8, rx);
    u_host.sel(1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp[$]);
    u_host.sel(1'b1);
    u_host.xfer(8'h13, 8, rx);
    u_host.xfer(a, 8, rx);
    foreach (exp[i]) begin
      u_host.xfer(8'h00, 8, rx);
      chk(rx, exp[i]);
    end
    u_host.sel(1'b0);
  endtask
  // ---------
  // Sequence
  // ---------
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    u_host.tick(1);
    chk({7'h00, latch}, 8'h00);
    frame('{8'h12, 8'h1E, 8'hFF, 8'h15, 8'h9A, 8'hFF});
    rd(8'h1E, '{8'h3F, 8'h15, 8'h9A, 8'hFF});
    frame('{8'h12, 8'h04, 8'h07});
    vcc <= 1'b0;
    u_host.tick(8);
    chk({7'h00, kept}, 8'h00);
    vcc <= 1'b1;
    rd(8'h06, '{8'h20});
    frame('{8'h12, 8'h04, 8'h0F});
    rd(8'h04, '{8'h2F});
    chk({7'h00, bbe}, 8'h01);
    vcc <= 1'b0;
    u_host.tick(8);
    chk({7'h00, kept}, 8'h01);
    vcc <= 1'b1;
    osc <= 1'b0;
    lp <= 1'b0;
    rd(8'h04, '{8'h1F, 8'h00, 8'h00});
    frame('{8'h06});
    chk({7'h00, latch}, 8'h01);
    frame('{8'h04});
    chk({7'h00, latch}, 8'h00);
    frame('{8'h06, 8'h02, 8'h00, 8'h11});
    chk({7'h00, latch}, 8'h00);
    frame('{8'h02, 8'h00, 8'h11});
    chk(nv_cnt[7:0], 8'h00);
    for (int i = 0; i < 3; i++) begin
      frame('{8'h06});
      frame('{ops[i], 8'h00, 8'h5A});
      chk(nv_cnt[7:0], 8'(i + 1));
      chk(nv_op, ops[i]);
      chk({7'h00, latch}, 8'h00);
    end
    frame('{8'h06});
    frame('{8'h02, 8'h00, 8'h5A}, 5);
    chk({7'h00, latch}, 8'h01);
    chk(nv_cnt[7:0], 8'h03);
    complete_run;
  end
  // Far above the roughly 3900 clocks the sequence needs
  initial begin
    #2000000;
    fails++;
    complete_run;
  end
endmodule
